//--- shared/adcc_consts.svh
// constants for the converter bus controller
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
`define ADCC_CLK_PERIOD_NS   4
`define ADCC_START_PULSE_NS  300
`define ADCC_START_CYC       ((`ADCC_START_PULSE_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_CONV_START_NS   700
`define ADCC_CONV_START_CYC  (`ADCC_CONV_START_NS / `ADCC_CLK_PERIOD_NS)
`define ADCC_ACCESS_NS       250
`define ADCC_ACCESS_CYC      ((`ADCC_ACCESS_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_FLOAT_NS        150
`define ADCC_FLOAT_CYC       ((`ADCC_FLOAT_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_CONV_NS         10000
`define ADCC_CONV_CYC        ((`ADCC_CONV_NS + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)
`define ADCC_CNT_W           12
`endif

//--- shared/adcc_pkg.sv
// types for the converter bus controller
package adcc_pkg;
    typedef enum logic [2:0] {
        ADCC_IDLE  = 3'h0,
        ADCC_START = 3'h1,
        ADCC_BUSY  = 3'h3,
        ADCC_SETUP = 3'h2,
        ADCC_READ  = 3'h6,
        ADCC_FLOAT = 3'h7
    } adcc_state_e;
endpackage

//--- design/adcc_host.sv
// host controller that starts conversions on the converter and reads the result
`timescale 1ns/1ps
`include "adcc_consts.svh"

module adcc_host (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       continuous_i,
    input  wire logic       stop_i,
    input  wire logic       bipolar_i,
    input  wire logic       twos_comp_i,
    input  wire logic       status_i,
    input  wire logic [7:0] data_i,
    output logic            chip_enable_n_o,
    output logic            device_select_n_o,
    output logic            read_not_write_o,
    output logic            bipolar_select_o,
    output logic            coding_select_o,
    output logic            busy_o,
    output logic [7:0]      result_o,
    output logic            result_valid_o,
    output logic            timeout_o
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic       status_m;
    logic       status_s;
    logic [7:0] data_m;
    logic [7:0] data_s;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status_m <= 1'b0;
            status_s <= 1'b0;
            data_m   <= 8'h00;
            data_s   <= 8'h00;
        end else begin
            status_m <= status_i;
            status_s <= status_m;
            data_m   <= data_i;
            data_s   <= data_m;
        end
    end

    // ----------------------------------------
    // shared decodes
    // ----------------------------------------
    // a start is taken only from idle and only while the device is quiet
    function automatic logic start_taken(input adcc_pkg::adcc_state_e st, input logic req, input logic dev_busy);
        return (st == adcc_pkg::ADCC_IDLE) && req && !dev_busy;
    endfunction

    // status never fell within one conversion plus the access time
    function automatic logic conv_overdue(input logic [`ADCC_CNT_W-1:0] count);
        return count >= `ADCC_CNT_W'(`ADCC_CONV_CYC + `ADCC_ACCESS_CYC);
    endfunction

    // read window covers the access time and the two synchroniser stages
    function automatic logic read_done(input logic [`ADCC_CNT_W-1:0] count);
        return count >= `ADCC_CNT_W'(`ADCC_ACCESS_CYC + 2);
    endfunction

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    adcc_pkg::adcc_state_e      state;
    logic [`ADCC_CNT_W-1:0]     cnt;
    logic                       cont;
    logic                       seen_busy;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state     <= adcc_pkg::ADCC_IDLE;
            cnt       <= '0;
            cont      <= 1'b0;
            seen_busy <= 1'b0;
        end else begin
            case (state)
                adcc_pkg::ADCC_IDLE: begin
                    cnt       <= '0;
                    seen_busy <= 1'b0;
                    if (start_taken(state, start_i, status_s)) begin
                        cont  <= continuous_i;
                        state <= adcc_pkg::ADCC_START;
                    end
                end
                adcc_pkg::ADCC_START: begin
                    // selects and rnw all low; count only the overlap
                    cnt <= cnt + 1'b1;
                    if (status_s) begin
                        seen_busy <= 1'b1;
                    end
                    if (cont) begin
                        // stay low: device converts back to back
                        if (stop_i && status_s) begin
                            cnt   <= '0;
                            state <= adcc_pkg::ADCC_BUSY;
                        end
                    end else if (cnt >= `ADCC_CNT_W'(`ADCC_START_CYC) &&
                                 (status_s || cnt >= `ADCC_CNT_W'(`ADCC_CONV_START_CYC))) begin
                        cnt   <= '0;
                        state <= adcc_pkg::ADCC_BUSY;
                    end
                end
                adcc_pkg::ADCC_BUSY: begin
                    cnt <= cnt + 1'b1;
                    if (status_s) begin
                        seen_busy <= 1'b1;
                    end
                    // wait for status to fall before reading
                    if ((seen_busy && !status_s) || conv_overdue(cnt)) begin
                        cnt   <= '0;
                        state <= adcc_pkg::ADCC_SETUP;
                    end
                end
                adcc_pkg::ADCC_SETUP: begin
                    // selects high, rnw high before selects fall
                    cnt   <= '0;
                    state <= adcc_pkg::ADCC_READ;
                end
                adcc_pkg::ADCC_READ: begin
                    cnt <= cnt + 1'b1;
                    if (read_done(cnt)) begin
                        cnt   <= '0;
                        state <= adcc_pkg::ADCC_FLOAT;
                    end
                end
                adcc_pkg::ADCC_FLOAT: begin
                    cnt <= cnt + 1'b1;
                    if (cnt >= `ADCC_CNT_W'(`ADCC_FLOAT_CYC)) begin
                        state <= adcc_pkg::ADCC_IDLE;
                    end
                end
                default: begin
                    state <= adcc_pkg::ADCC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            chip_enable_n_o   <= 1'b1;
            device_select_n_o <= 1'b1;
            read_not_write_o  <= 1'b1;
        end else begin
            case (state)
                adcc_pkg::ADCC_START: begin
                    chip_enable_n_o   <= 1'b0;
                    device_select_n_o <= 1'b0;
                    read_not_write_o  <= 1'b0;
                end
                adcc_pkg::ADCC_READ: begin
                    chip_enable_n_o   <= 1'b0;
                    device_select_n_o <= 1'b0;
                    read_not_write_o  <= 1'b1;
                end
                default: begin
                    chip_enable_n_o   <= 1'b1;
                    device_select_n_o <= 1'b1;
                    read_not_write_o  <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bipolar_select_o <= 1'b0;
            coding_select_o  <= 1'b0;
        end else if (start_taken(state, start_i, status_s)) begin
            bipolar_select_o <= bipolar_i;
            coding_select_o  <= twos_comp_i;
        end
    end

    // ----------------------------------------
    // result capture
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            result_o       <= 8'h00;
            result_valid_o <= 1'b0;
            busy_o         <= 1'b0;
            timeout_o      <= 1'b0;
        end else begin
            busy_o         <= (state != adcc_pkg::ADCC_IDLE);
            result_valid_o <= 1'b0;
            if (start_taken(state, start_i, status_s)) begin
                timeout_o <= 1'b0;
            end
            if (state == adcc_pkg::ADCC_BUSY && conv_overdue(cnt) && !(seen_busy && !status_s)) begin
                timeout_o <= 1'b1;
            end
            // sample at the end of the read, once the access time and both synchroniser stages have passed
            if (state == adcc_pkg::ADCC_READ && read_done(cnt)) begin
                result_o       <= data_s;
                result_valid_o <= 1'b1;
            end
        end
    end

endmodule

//--- tb/adcc_host_sva.sv
// pin checker for the converter bus controller
`timescale 1ns/1ps
module adcc_host_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic status_i,
    input wire logic chip_enable_n_o,
    input wire logic device_select_n_o,
    input wire logic read_not_write_o,
    input wire logic bipolar_select_o,
    input wire logic coding_select_o
);
    logic [11:0] low_cnt;
    logic [6:0]  rd_cnt;
    wire         all_low = !chip_enable_n_o && !device_select_n_o && !read_not_write_o;
    always_ff @(posedge core_clk_i) begin
        low_cnt <= (rst_i || !all_low) ? 12'h000 : low_cnt + {11'h000, low_cnt != 12'hFFF};
    end
    always_ff @(posedge core_clk_i) begin
        rd_cnt <= (rst_i || chip_enable_n_o || !read_not_write_o) ? 7'h00 : rd_cnt + {6'h00, rd_cnt != 7'h7F};
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_start_end;
        $past(all_low) && !all_low;
    endsequence
    sequence s_read_end;
        $rose(chip_enable_n_o) && $past(read_not_write_o);
    endsequence
    a_selects_equal: assert property (chip_enable_n_o == device_select_n_o)
        else $error("selects differ");
    a_start_held: assert property (s_start_end |-> low_cnt >= 12'h04B)
        else $error("start too short");
    a_read_window: assert property (s_read_end |-> rd_cnt >= 7'h3F)
        else $error("read too short");
    a_rnw_rise: assert property ($rose(read_not_write_o) && $past(all_low) |-> status_i || $past(status_i, 3))
        else $error("rnw rose with status low");
    a_mode_stable: assert property (all_low |-> $stable(bipolar_select_o) && $stable(coding_select_o))
        else $error("mode pins moved");
    a_no_start_busy: assert property ($rose(all_low) |-> !status_i)
        else $error("start while converting");
    a_reset_idle: assert property ($fell(rst_i) |-> chip_enable_n_o && read_not_write_o)
        else $error("pins active after reset");
endmodule
bind adcc_host adcc_host_chk i_chk (.*);

//--- tb/adcc_dev_model.sv
// behavioural model of the converter seen from its control pins
`timescale 1ns/1ps
module adcc_dev_model #(
    parameter int         CONV_CYC = 300,
    parameter logic [7:0] RAW      = 8'hA5
) (
    input  wire logic  clk_i,
    input  wire logic  ce_n_i,
    input  wire logic  cs_n_i,
    input  wire logic  rnw_i,
    input  wire logic  fmt_i,
    output logic       status_o,
    output logic [7:0] data_o
);
    logic [11:0] low_cnt  = 12'h000;
    logic [11:0] conv_cnt = 12'h000;
    logic [5:0]  rd_cnt   = 6'h00;
    logic [7:0]  res      = 8'h00;
    logic [7:0]  pat      = 8'h00;
    logic        conv     = 1'b0;
    wire         sel      = !ce_n_i && !cs_n_i;
    always @(posedge clk_i) begin
        pat     <= pat + 8'h3B;
        low_cnt <= (sel && !rnw_i) ? low_cnt + 12'h001 : 12'h000;
        rd_cnt  <= (sel && rnw_i && !conv) ? rd_cnt + {5'h00, rd_cnt != 6'h3F} : 6'h00;
        if (!conv && low_cnt >= 12'h04B) begin
            conv     <= 1'b1;
            conv_cnt <= 12'h000;
        end else if (conv) begin
            conv_cnt <= conv_cnt + 12'h001;
            if (conv_cnt == 12'(CONV_CYC - 1)) begin
                conv    <= 1'b0;
                res     <= RAW ^ {fmt_i, 7'h00};
                low_cnt <= 12'h000;
            end
        end
    end
    // undriven bus shows a moving pattern, valid only after the access time
    assign data_o   = (sel && rnw_i && !conv && rd_cnt >= 6'h3E) ? res : ~pat;
    assign status_o = conv;
endmodule

//--- tb/adc_bus_control_timing_test.sv
// self-checking bench for the converter bus controller
`timescale 1ns/1ps
module adc_bus_control_timing_test;
    localparam logic [7:0] RAW = 8'hA5;
    logic       core_clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, continuous_i = 1'b0, stop_i = 1'b0;
    logic       bipolar_i = 1'b0, twos_comp_i = 1'b0, status_i, chip_enable_n_o, device_select_n_o;
    logic       read_not_write_o, bipolar_select_o, coding_select_o, busy_o, result_valid_o, timeout_o;
    logic [7:0] data_i, result_o;
    int         n_mismatch = 0;
    int         checks = 0;
    always #2 core_clk_i = ~core_clk_i;
    adcc_host i_dut (.*);
    adcc_dev_model #(.RAW(RAW)) i_dev (.clk_i(core_clk_i), .ce_n_i(chip_enable_n_o), .cs_n_i(device_select_n_o),
        .rnw_i(read_not_write_o), .fmt_i(coding_select_o), .status_o(status_i), .data_o(data_i));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic go(input logic c, input logic b, input logic f);
        continuous_i = c;
        bipolar_i = b;
        twos_comp_i = f;
        start_i = 1'b1;
        tick(1);
        start_i = 1'b0;
    endtask
    task automatic wait_valid;
        for (int i = 0; i < 4000 && result_valid_o !== 1'b1; i++) tick(1);
        cmp({7'h00, result_valid_o}, 8'h01);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 4000 && busy_o !== 1'b0; i++) tick(1);
        cmp({7'h00, busy_o}, 8'h00);
        tick(1);
    endtask
    task automatic t_single;
        for (int k = 0; k < 4; k++) begin
            go(1'b0, k[1], k[0]);
            wait_valid();
            cmp({7'h00, timeout_o}, 8'h00);
            cmp(result_o, RAW ^ {k[0], 7'h00});
            cmp({7'h00, bipolar_select_o}, {7'h00, k[1]});
            wait_idle();
        end
        $display("single conversions done");
    endtask
    task automatic t_refuse;
        go(1'b0, 1'b0, 1'b0);
        tick(20);
        go(1'b0, 1'b1, 1'b1);
        wait_valid();
        cmp(result_o, RAW);
        wait_idle();
        tick(10);
        cmp({7'h00, busy_o}, 8'h00);
        $display("refused start done");
    endtask
    task automatic t_cont;
        int   rises = 0;
        logic prev = 1'b0;
        go(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 3000 && rises < 2; i++) begin
            rises += int'(status_i && !prev);
            prev = status_i;
            tick(1);
        end
        stop_i = 1'b1;
        wait_valid();
        stop_i = 1'b0;
        cmp({7'h00, timeout_o}, 8'h00);
        cmp({7'h00, rises >= 2}, 8'h01);
        cmp(result_o, RAW ^ 8'h80);
        wait_idle();
        $display("continuous run done");
    endtask
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        tick(5);
        rst_i = 1'b0;
        t_single();
        t_refuse();
        t_cont();
        end_of_test();
    end
endmodule
